// *** bench/csi_dphy_timing_override_regs_tb.sv ***
`timescale 1ns/1ps
module csi_dphy_timing_override_regs_tb;
  logic clock = 1'b0;
  logic reset_n = 1'b0;
  logic [11:0] s_axi_awaddr = '0;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_awready;
  logic [31:0] s_axi_wdata = '0;
  logic [3:0] s_axi_wstrb = '0;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_wready;
  logic [1:0] s_axi_bresp;
  logic s_axi_bvalid;
  logic s_axi_bready = 1'b0;
  logic [11:0] s_axi_araddr = '0;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_arready;
  logic [31:0] s_axi_rdata;
  logic [1:0] s_axi_rresp;
  logic s_axi_rvalid;
  logic s_axi_rready = 1'b0;
  dphy_timing_pkg::port0_timing_t port0Auto = '0;
  dphy_timing_pkg::port1_timing_t port1Auto = '0;
  dphy_timing_pkg::port0_timing_t port0Timing;
  dphy_timing_pkg::port1_timing_t port1Timing;
  int fails = 0;
  int samples_checked = 0;
  int cycles = 0;
  int seed = 32'hf09c_83e2;
  int slot;
  bit ovr [7];
  logic [6:0] val [7];
  logic [6:0] autoV [7];
  logic [1:0] resp;
  logic [31:0] rd;
  logic [7:0] idxTab [7] = '{dphy_timing_pkg::IDX_PORT0_HS_TRAIL, dphy_timing_pkg::IDX_PORT0_HS_EXIT,
    dphy_timing_pkg::IDX_PORT0_LP_EXCL, dphy_timing_pkg::IDX_PORT1_CLK_PREPARE, dphy_timing_pkg::IDX_PORT1_CLK_ZERO,
    dphy_timing_pkg::IDX_PORT1_CLK_TRAIL, dphy_timing_pkg::IDX_PORT1_CLK_POST};

  csi_dphy_timing_override_regs u_csi_dphy_timing_override_regs (
    .clock(clock), .reset_n(reset_n),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .port0Auto(port0Auto), .port1Auto(port1Auto), .port0Timing(port0Timing), .port1Timing(port1Timing)
  );

  always #2 clock = ~clock;

  // Whole run needs well under two thousand cycles
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fails = fails + 1;
      report_and_stop();
    end
  end

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : report_and_stop

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // Entered just after a rising edge; each channel held until its own ready
  task automatic axi_write(input logic [7:0] idx, input logic [7:0] d, input logic [3:0] strb, output logic [1:0] r);
    bit awDone;
    bit wDone;
    awDone = 1'b0;
    wDone = 1'b0;
    s_axi_awaddr <= {2'b00, idx, 2'b00};
    s_axi_wdata <= {24'h00_0000, d};
    s_axi_wstrb <= strb;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (!(awDone && wDone)) begin
      @(posedge clock);
      if (!awDone && s_axi_awready === 1'b1) begin
        awDone = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!wDone && s_axi_wready === 1'b1) begin
        wDone = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    s_axi_bready <= 1'b1;
    do @(posedge clock); while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : axi_write

  task automatic axi_read(input logic [7:0] idx, output logic [31:0] d, output logic [1:0] r);
    s_axi_araddr <= {2'b00, idx, 2'b00};
    s_axi_arvalid <= 1'b1;
    do @(posedge clock); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    s_axi_rready <= 1'b1;
    do @(posedge clock); while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : axi_read

  function automatic logic [6:0] exp_out(input int i);
    return ovr[i] ? val[i] : autoV[i];
  endfunction : exp_out

  task automatic read_slot(input int i);
    axi_read(idxTab[i], rd, resp);
    check("read resp", resp, dphy_timing_pkg::RESP_OKAY);
    check("read data", rd, {24'h00_0000, ovr[i], exp_out(i)});
  endtask : read_slot

  task automatic write_slot(input int i, input logic [7:0] d);
    axi_write(idxTab[i], d, 4'h1, resp);
    check("write resp", resp, dphy_timing_pkg::RESP_OKAY);
    ovr[i] = d[7];
    if (d[7]) val[i] = d[6:0];
  endtask : write_slot

  task automatic check_outputs();
    repeat (2) @(posedge clock);
    check("port0 hs trail", port0Timing.hsTrail, exp_out(0));
    check("port0 hs exit", port0Timing.hsExit, exp_out(1));
    check("port0 lp excl", port0Timing.lpExcl, exp_out(2));
    check("port1 clk prepare", port1Timing.clkPrepare, exp_out(3));
    check("port1 clk zero", port1Timing.clkZero, exp_out(4));
    check("port1 clk trail", port1Timing.clkTrail, exp_out(5));
    check("port1 clk post", port1Timing.clkPost, exp_out(6));
  endtask : check_outputs

  task automatic new_auto();
    for (int i = 0; i < 7; i++) autoV[i] = 7'($random(seed));
    port0Auto <= {autoV[0], autoV[1], autoV[2]};
    port1Auto <= {autoV[3], autoV[4], autoV[5], autoV[6]};
  endtask : new_auto

  task automatic do_reset();
    reset_n <= 1'b0;
    repeat (8) @(posedge clock);
    reset_n <= 1'b1;
    for (int i = 0; i < 7; i++) begin
      ovr[i] = 1'b0;
      val[i] = 7'h00;
    end
    @(posedge clock);
  endtask : do_reset

  task automatic read_all();
    for (int i = 0; i < 7; i++) read_slot(i);
    check_outputs();
  endtask : read_all

  initial begin
    new_auto();
    do_reset();
    read_all();
    for (int i = 0; i < 7; i++) begin
      write_slot(i, {1'b0, 7'($random(seed))});
      read_slot(i);
      write_slot(i, {1'b1, 7'($random(seed))});
      read_slot(i);
      check_outputs();
      new_auto();
      @(posedge clock);
      read_slot(i);
      check_outputs();
      write_slot(i, 8'h00);
      read_slot(i);
      check_outputs();
    end
    // Value field extremes
    write_slot(6, 8'hFF);
    read_slot(6);
    write_slot(6, 8'h80);
    read_slot(6);
    // Unmapped index and a write with the low byte lane off must leave everything alone
    axi_write(8'h49, 8'hFF, 4'h1, resp);
    check("unmapped write resp", resp, dphy_timing_pkg::RESP_SLVERR);
    axi_read(8'h49, rd, resp);
    check("unmapped read resp", resp, dphy_timing_pkg::RESP_SLVERR);
    axi_write(idxTab[0], 8'hFF, 4'h0, resp);
    check("no strobe resp", resp, dphy_timing_pkg::RESP_OKAY);
    read_all();
    for (int n = 0; n < 60; n++) begin
      slot = {$random(seed)} % 7;
      case ({$random(seed)} % 3)
        0: write_slot(slot, 8'($random(seed)));
        1: read_slot(slot);
        default: begin
          new_auto();
          @(posedge clock);
        end
      endcase
    end
    read_all();
    // Reset in mid-run drops every override
    do_reset();
    read_all();
    report_and_stop();
  end
endmodule : csi_dphy_timing_override_regs_tb

// *** rtl/csi_dphy_timing_override_regs.sv ***
// The AXI4-Lite slave port was left to the implementer.
`timescale 1ns/1ps
// Summary of operation
// - Port 0 HS trail time is automatic unless its override bit is set, then the stored 7-bit value is used.
// - Port 0 HS exit time is automatic unless its override bit is set, then the stored 7-bit value is used.
// - Port 0 LP exclusive time is automatic unless its override bit is set, then the stored value is used.
// - Port 1 clock prepare time is automatic unless its override bit is set, then the stored value is used.
// - Port 1 clock zero time is automatic unless its override bit is set, then the stored value is used.
// - Port 1 clock trail time is automatic unless its override bit is set, then the stored value is used.
// - Port 1 clock post time is automatic unless its override bit is set, then the stored value is used.
// - With override clear the value field is read-only and reads the current automatic value.
// - With override set the value field is writable and reads back the stored value.
// - Every register resets to zero, so automatic timing is in force after reset.
module csi_dphy_timing_override_regs (
  // Clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // AXI4-Lite write address
  input wire logic [dphy_timing_pkg::ADDR_WIDTH-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address
  input wire logic [dphy_timing_pkg::ADDR_WIDTH-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Automatically derived timing
  input wire dphy_timing_pkg::port0_timing_t port0Auto,
  input wire dphy_timing_pkg::port1_timing_t port1Auto,
  // Chosen timing to the lane sequencers
  output dphy_timing_pkg::port0_timing_t port0Timing,
  output dphy_timing_pkg::port1_timing_t port1Timing
);

  localparam int N = dphy_timing_pkg::NUM_TIMING;
  localparam int VW = dphy_timing_pkg::VALUE_WIDTH;

  localparam logic [7:0] IDX_TABLE [N] = '{
    dphy_timing_pkg::IDX_PORT0_HS_TRAIL,
    dphy_timing_pkg::IDX_PORT0_HS_EXIT,
    dphy_timing_pkg::IDX_PORT0_LP_EXCL,
    dphy_timing_pkg::IDX_PORT1_CLK_PREPARE,
    dphy_timing_pkg::IDX_PORT1_CLK_ZERO,
    dphy_timing_pkg::IDX_PORT1_CLK_TRAIL,
    dphy_timing_pkg::IDX_PORT1_CLK_POST
  };

  logic awHeld;
  logic wHeld;
  logic [dphy_timing_pkg::ADDR_WIDTH-1:0] awAddr;
  logic [7:0] wByte;
  logic wLane0;
  dphy_timing_pkg::wr_state_t wrState;
  logic doWrite;
  logic [VW-1:0] autoVec [N];
  logic [VW-1:0] chosenVec [N];
  logic [7:0] readVec [N];
  dphy_timing_pkg::timing_reg_t storedVec [N];
  logic [N-1:0] writeHitVec;
  logic [N-1:0] readHitVec;
  logic writeMapped;
  logic [7:0] readByte;
  logic readMapped;

  assign autoVec[0] = port0Auto.hsTrail;
  assign autoVec[1] = port0Auto.hsExit;
  assign autoVec[2] = port0Auto.lpExcl;
  assign autoVec[3] = port1Auto.clkPrepare;
  assign autoVec[4] = port1Auto.clkZero;
  assign autoVec[5] = port1Auto.clkTrail;
  assign autoVec[6] = port1Auto.clkPost;

  // Address and data taken independently, in either order
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      awHeld <= 1'b0;
      awAddr <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      awHeld <= 1'b1;
      awAddr <= s_axi_awaddr;
    end else if (doWrite) begin
      awHeld <= 1'b0;
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      wHeld <= 1'b0;
      wByte <= '0;
      wLane0 <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      wHeld <= 1'b1;
      wByte <= s_axi_wdata[7:0];
      wLane0 <= s_axi_wstrb[0];
    end else if (doWrite) begin
      wHeld <= 1'b0;
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
    end else begin
      s_axi_awready <= !(awHeld || (s_axi_awvalid && s_axi_awready)) || doWrite;
      s_axi_wready <= !(wHeld || (s_axi_wvalid && s_axi_wready)) || doWrite;
      if (doWrite) begin
        s_axi_awready <= 1'b0;
        s_axi_wready <= 1'b0;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  assign doWrite = awHeld && wHeld && (wrState == dphy_timing_pkg::WR_IDLE);

  always_comb begin
    writeMapped = 1'b0;
    readMapped = 1'b0;
    readByte = '0;
    for (int i = 0; i < N; i++) begin
      writeHitVec[i] = doWrite && wLane0 && (awAddr == dphy_timing_pkg::byte_addr(IDX_TABLE[i]));
      readHitVec[i] = s_axi_araddr == dphy_timing_pkg::byte_addr(IDX_TABLE[i]);
      writeMapped = writeMapped || (awAddr == dphy_timing_pkg::byte_addr(IDX_TABLE[i]));
      readMapped = readMapped || readHitVec[i];
      if (readHitVec[i]) begin
        readByte = readVec[i];
      end
    end
  end

  // Write response; unmapped addresses answer SLVERR and change nothing
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      wrState <= dphy_timing_pkg::WR_IDLE;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= dphy_timing_pkg::RESP_OKAY;
    end else begin
      case (wrState)
        dphy_timing_pkg::WR_IDLE: begin
          if (doWrite) begin
            wrState <= dphy_timing_pkg::WR_RESP;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= writeMapped ? dphy_timing_pkg::RESP_OKAY : dphy_timing_pkg::RESP_SLVERR;
          end
        end
        dphy_timing_pkg::WR_RESP: begin
          if (s_axi_bready) begin
            wrState <= dphy_timing_pkg::WR_IDLE;
            s_axi_bvalid <= 1'b0;
          end
        end
        default: begin
          wrState <= dphy_timing_pkg::WR_IDLE;
          s_axi_bvalid <= 1'b0;
        end
      endcase
    end
  end

  // Read: one cycle from address to data; address refused while data is pending
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= dphy_timing_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= {24'h00_0000, readByte};
      s_axi_rresp <= readMapped ? dphy_timing_pkg::RESP_OKAY : dphy_timing_pkg::RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
    end
  end

  for (genvar g = 0; g < N; g++) begin : gen_slot
    timing_override_slot u_slot (
      .clock(clock),
      .reset_n(reset_n),
      .writeHit(writeHitVec[g]),
      .writeByte(wByte),
      .autoValue(autoVec[g]),
      .stored(storedVec[g]),
      .chosen(chosenVec[g]),
      .readback(readVec[g])
    );
  end

  // Structs rebuilt from flopped per-slot choices
  assign port0Timing.hsTrail = chosenVec[0];
  assign port0Timing.hsExit = chosenVec[1];
  assign port0Timing.lpExcl = chosenVec[2];
  assign port1Timing.clkPrepare = chosenVec[3];
  assign port1Timing.clkZero = chosenVec[4];
  assign port1Timing.clkTrail = chosenVec[5];
  assign port1Timing.clkPost = chosenVec[6];

  property p_override_select;
    @(posedge clock) disable iff (!reset_n)
    storedVec[0].overrideEn |=> port0Timing.hsTrail == $past(storedVec[0].value);
  endproperty
  a_override_select: assert property (p_override_select) else $error("trail override not used");

  property p_auto_exit;
    @(posedge clock) disable iff (!reset_n)
    !storedVec[1].overrideEn |=> port0Timing.hsExit == $past(port0Auto.hsExit);
  endproperty
  a_auto_exit: assert property (p_auto_exit) else $error("exit auto value not used");

  property p_lp_excl;
    @(posedge clock) disable iff (!reset_n)
    1'b1 |=> port0Timing.lpExcl == ($past(storedVec[2].overrideEn) ? $past(storedVec[2].value) : $past(port0Auto.lpExcl));
  endproperty
  a_lp_excl: assert property (p_lp_excl) else $error("lp exclusive choice wrong");

  property p_clk_prepare;
    @(posedge clock) disable iff (!reset_n)
    1'b1 |=> port1Timing.clkPrepare == ($past(storedVec[3].overrideEn) ? $past(storedVec[3].value) : $past(port1Auto.clkPrepare));
  endproperty
  a_clk_prepare: assert property (p_clk_prepare) else $error("clock prepare choice wrong");

  property p_clk_post;
    @(posedge clock) disable iff (!reset_n)
    !storedVec[6].overrideEn |=> port1Timing.clkPost == $past(port1Auto.clkPost);
  endproperty
  a_clk_post: assert property (p_clk_post) else $error("clock post auto value not used");

  property p_read_auto;
    @(posedge clock) disable iff (!reset_n)
    (s_axi_arvalid && s_axi_arready && readHitVec[5] && !storedVec[5].overrideEn)
      |=> s_axi_rdata[7:0] == {1'b0, $past(port1Auto.clkTrail)};
  endproperty
  a_read_auto: assert property (p_read_auto) else $error("read of clear override not auto value");

  property p_write_stored;
    @(posedge clock) disable iff (!reset_n)
    (writeHitVec[4] && wByte[dphy_timing_pkg::ENABLE_BIT]) |=> storedVec[4].value == $past(wByte[VW-1:0]);
  endproperty
  a_write_stored: assert property (p_write_stored) else $error("enabled write not stored");

  property p_write_ignored;
    @(posedge clock) disable iff (!reset_n)
    (writeHitVec[0] && !wByte[dphy_timing_pkg::ENABLE_BIT])
      |=> storedVec[0].value == $past(storedVec[0].value) && !storedVec[0].overrideEn;
  endproperty
  a_write_ignored: assert property (p_write_ignored) else $error("value changed with override clear");

  property p_reset_clear;
    @(posedge clock) $rose(reset_n) |-> !storedVec[3].overrideEn && storedVec[3].value == '0;
  endproperty
  a_reset_clear: assert property (p_reset_clear) else $error("register not zero after reset");

  property p_exit_override;
    @(posedge clock) disable iff (!reset_n)
    storedVec[1].overrideEn |=> port0Timing.hsExit == $past(storedVec[1].value);
  endproperty
  a_exit_override: assert property (p_exit_override) else $error("exit override not used");

  property p_clk_zero;
    @(posedge clock) disable iff (!reset_n)
    1'b1 |=> port1Timing.clkZero == ($past(storedVec[4].overrideEn) ? $past(storedVec[4].value) : $past(port1Auto.clkZero));
  endproperty
  a_clk_zero: assert property (p_clk_zero) else $error("clock zero choice wrong");

  property p_clk_trail;
    @(posedge clock) disable iff (!reset_n)
    1'b1 |=> port1Timing.clkTrail == ($past(storedVec[5].overrideEn) ? $past(storedVec[5].value) : $past(port1Auto.clkTrail));
  endproperty
  a_clk_trail: assert property (p_clk_trail) else $error("clock trail choice wrong");

  property p_read_stored;
    @(posedge clock) disable iff (!reset_n)
    (s_axi_arvalid && s_axi_arready && readHitVec[1] && storedVec[1].overrideEn)
      |=> s_axi_rdata[7:0] == {1'b1, $past(storedVec[1].value)};
  endproperty
  a_read_stored: assert property (p_read_stored) else $error("read of set override not stored value");

  property p_value_kept;
    @(posedge clock) disable iff (!reset_n)
    (writeHitVec[6] && !wByte[dphy_timing_pkg::ENABLE_BIT]) |=> $stable(storedVec[6].value);
  endproperty
  a_value_kept: assert property (p_value_kept) else $error("clock post value changed with override clear");

  // Every slot, not just one, must come out of reset on automatic timing
  property p_reset_all_auto;
    @(posedge clock) $rose(reset_n) |->
      !storedVec[0].overrideEn && !storedVec[1].overrideEn && !storedVec[2].overrideEn && !storedVec[3].overrideEn
      && !storedVec[4].overrideEn && !storedVec[5].overrideEn && !storedVec[6].overrideEn;
  endproperty
  a_reset_all_auto: assert property (p_reset_all_auto) else $error("override enable set after reset");

endmodule : csi_dphy_timing_override_regs

// *** rtl/timing_override_slot.sv ***
`timescale 1ns/1ps
module timing_override_slot (
  // Clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // Register write
  input wire logic writeHit,
  input wire logic [7:0] writeByte,
  // Automatic value
  input wire logic [dphy_timing_pkg::VALUE_WIDTH-1:0] autoValue,
  // Results
  output dphy_timing_pkg::timing_reg_t stored,
  output logic [dphy_timing_pkg::VALUE_WIDTH-1:0] chosen,
  output logic [7:0] readback
);

  logic newEnable;

  assign newEnable = writeByte[dphy_timing_pkg::ENABLE_BIT];

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      stored <= dphy_timing_pkg::TIMING_RESET;
    end else if (writeHit) begin
      stored.overrideEn <= newEnable;
      // Value only lands when the override is on in this write
      if (newEnable) begin
        stored.value <= writeByte[dphy_timing_pkg::VALUE_WIDTH-1:0];
      end
    end
  end

  // Chosen view registered so top timing outputs come from flops; the read view below is combinational
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      chosen <= '0;
    end else begin
      chosen <= stored.overrideEn ? stored.value : autoValue;
    end
  end

  always_comb begin
    readback = {stored.overrideEn, stored.overrideEn ? stored.value : autoValue};
  end

endmodule : timing_override_slot

// *** shared/dphy_timing_pkg.sv ***
package dphy_timing_pkg;

  localparam int NUM_TIMING = 7;
  localparam int VALUE_WIDTH = 7;
  localparam int ENABLE_BIT = 7;
  localparam int ADDR_WIDTH = 12;

  // Register indices; the byte address is four times the index
  localparam logic [7:0] IDX_PORT0_HS_TRAIL = 8'h46;
  localparam logic [7:0] IDX_PORT0_HS_EXIT = 8'h47;
  localparam logic [7:0] IDX_PORT0_LP_EXCL = 8'h48;
  localparam logic [7:0] IDX_PORT1_CLK_PREPARE = 8'h60;
  localparam logic [7:0] IDX_PORT1_CLK_ZERO = 8'h61;
  localparam logic [7:0] IDX_PORT1_CLK_TRAIL = 8'h62;
  localparam logic [7:0] IDX_PORT1_CLK_POST = 8'h63;

  localparam logic [7:0] TIMING_RESET = 8'h00;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic overrideEn;
    logic [VALUE_WIDTH-1:0] value;
  } timing_reg_t;

  // Per-port chosen values toward the lane-timing sequencers
  typedef struct packed {
    logic [VALUE_WIDTH-1:0] hsTrail;
    logic [VALUE_WIDTH-1:0] hsExit;
    logic [VALUE_WIDTH-1:0] lpExcl;
  } port0_timing_t;

  typedef struct packed {
    logic [VALUE_WIDTH-1:0] clkPrepare;
    logic [VALUE_WIDTH-1:0] clkZero;
    logic [VALUE_WIDTH-1:0] clkTrail;
    logic [VALUE_WIDTH-1:0] clkPost;
  } port1_timing_t;

  typedef enum logic [1:0] {
    WR_IDLE = 2'b00,
    WR_RESP = 2'b01
  } wr_state_t;

  function automatic logic [ADDR_WIDTH-1:0] byte_addr(input logic [7:0] idx);
    byte_addr = {2'b00, idx, 2'b00};
  endfunction : byte_addr

endpackage : dphy_timing_pkg
